// ===== hw/ptmr_pkg.sv
// Shared constants, types and helpers for the target memory responder and the core-side end.
// Assumes a 64-bit transaction stream with the BAR match vector on user bits 9:2.
package ptmr_pkg;

  // ----------------------------------------------------------------
  // Stream geometry
  // ----------------------------------------------------------------
  localparam int DATA_W = 64;
  localparam int KEEP_W = 8;
  localparam int USER_W = 22;
  localparam int HIT_LSB = 2;
  localparam int HIT_W = 8;
  localparam logic [KEEP_W-1:0] KEEP_ALL = 8'hFF;
  localparam logic [KEEP_W-1:0] KEEP_LOW = 8'h0F;

  // ----------------------------------------------------------------
  // Regions: four rams of 2 KB, 512 words of 32 bits each
  // ----------------------------------------------------------------
  localparam int REGION_COUNT = 4;
  localparam int REGION_BYTES = 2048;
  localparam int TARGET_BYTES = 8192;
  localparam int WORD_AW = 9;
  localparam int REGION_WORDS = REGION_BYTES / 4;
  localparam logic [1:0] RGN_IO = 2'h0;
  localparam logic [1:0] RGN_MEM32 = 2'h1;
  localparam logic [1:0] RGN_MEM64 = 2'h2;
  localparam logic [1:0] RGN_EXPROM = 2'h3;

  // Match vector bits that select each region.
  localparam int HIT_IO_BIT = 0;
  localparam int HIT_MEM64_BIT = 1;
  localparam int HIT_MEM32_BIT = 2;
  localparam int HIT_EXPROM_BIT = 6;

  // ----------------------------------------------------------------
  // Header fields, taken as {fmt, type}
  // ----------------------------------------------------------------
  localparam logic [6:0] FT_MRD32 = 7'h00;
  localparam logic [6:0] FT_MRD64 = 7'h20;
  localparam logic [6:0] FT_MWR32 = 7'h40;
  localparam logic [6:0] FT_MWR64 = 7'h60;
  localparam logic [6:0] FT_IORD = 7'h02;
  localparam logic [6:0] FT_IOWR = 7'h42;
  localparam logic [6:0] FT_CPL = 7'h0A;
  localparam logic [6:0] FT_CPLD = 7'h4A;
  localparam logic [9:0] LEN_ONE_DW = 10'h001;
  localparam logic [2:0] CPL_STATUS_SC = 3'h0;
  localparam logic [11:0] IO_WR_BYTE_COUNT = 12'h004;

  typedef enum logic [2:0] {
    S_IDLE    = 3'b000,
    S_ADDR    = 3'b001,
    S_DATA    = 3'b010,
    S_DISCARD = 3'b011,
    S_WRITE   = 3'b100,
    S_READ    = 3'b101,
    S_CPL0    = 3'b110,
    S_CPL1    = 3'b111
  } ptmr_state_t;

  // ----------------------------------------------------------------
  // Byte-enable helpers for completion headers
  // ----------------------------------------------------------------
  function automatic logic [1:0] ptmr_first_byte(input logic [3:0] be);
    if (be[0]) return 2'h0;
    else if (be[1]) return 2'h1;
    else if (be[2]) return 2'h2;
    else if (be[3]) return 2'h3;
    else return 2'h0;
  endfunction : ptmr_first_byte

  // A zero first enable still reports one byte, as a zero-length read must.
  function automatic logic [11:0] ptmr_byte_count(input logic [3:0] be);
    if (be[3] && be[0]) return 12'h004;
    else if ((be[3] && be[1]) || (be[2] && be[0])) return 12'h003;
    else if (be[3] || be[2] || be[1]) return (be[3] ? 12'h001 : 12'h001) + {10'h000, 2'(be[3] & be[2])}
      + {10'h000, 2'(be[2] & be[1])} + {10'h000, 2'(be[1] & be[0])};
    else return 12'h001;
  endfunction : ptmr_byte_count

endpackage : ptmr_pkg

// ===== hw/ptmr_axis_if.sv
// Receive and transmit transaction streams between the endpoint core and the responder.
// Assumes both ends share one clock; the testbench instantiates it and clocks both ends.
`timescale 1ns/1ps
interface ptmr_axis_if;
  import ptmr_pkg::*;
  logic [DATA_W-1:0] rx_tdata;
  logic [KEEP_W-1:0] rx_tkeep;
  logic rx_tlast;
  logic rx_tvalid;
  logic rx_tready;
  logic [USER_W-1:0] rx_tuser;
  logic [DATA_W-1:0] tx_tdata;
  logic [KEEP_W-1:0] tx_tkeep;
  logic tx_tlast;
  logic tx_tvalid;
  logic tx_tready;

  modport device_mp (
    input rx_tdata, rx_tkeep, rx_tlast, rx_tvalid, rx_tuser, tx_tready,
    output rx_tready, tx_tdata, tx_tkeep, tx_tlast, tx_tvalid
  );
  modport core_mp (
    output rx_tdata, rx_tkeep, rx_tlast, rx_tvalid, rx_tuser, tx_tready,
    input rx_tready, tx_tdata, tx_tkeep, tx_tlast, tx_tvalid
  );
endinterface : ptmr_axis_if

// ===== hw/ptmr_region_ram.sv
// One 2 KB target region: dual-port ram, byte-masked write port and registered read port.
// Assumes a single clock; read data holds until the next read enable.
`timescale 1ns/1ps
module ptmr_region_ram
  import ptmr_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // asynchronous reset, active low
  input wire logic wr_en, // write strobe
  input wire logic [WORD_AW-1:0] wr_addr, // word address of write
  input wire logic [3:0] wr_be, // byte enables of write
  input wire logic [31:0] wr_data, // write data
  input wire logic rd_en, // read strobe
  input wire logic [WORD_AW-1:0] rd_addr, // word address of read
  output logic [31:0] rd_data // read data, one cycle after rd_en
);
  logic [31:0] mem [0:REGION_WORDS-1];

  always_ff @(posedge clk_sys)
  begin
    for (int b = 0; b < 4; b++)
    begin
      if (wr_en && wr_be[b])
        mem[wr_addr][b*8 +: 8] <= wr_data[b*8 +: 8];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      rd_data <= 32'h0000_0000;
    else if (rd_en)
      rd_data <= mem[rd_addr];
  end
endmodule : ptmr_region_ram

// ===== hw/ptmr_device.sv
// Target-only memory responder behind the endpoint core's transaction streams.
// Assumes well-formed packets from the core and the 64-bit stream variant.
`timescale 1ns/1ps
module ptmr_device
  import ptmr_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // asynchronous reset, active low
  input wire logic [15:0] completer_id, // our bus/device/function number
  output logic busy, // request in hand
  ptmr_axis_if.device_mp link // streams to the core
);

  // ----------------------------------------------------------------
  // State and captured request
  // ----------------------------------------------------------------
  ptmr_state_t state_reg, state_next;
  logic rx_tready_reg;
  logic busy_reg;
  logic is_write_reg, is_io_reg, is64_reg;
  logic [1:0] region_reg;
  logic [2:0] tc_reg;
  logic [1:0] attr_reg;
  logic [15:0] rid_reg;
  logic [7:0] tag_reg;
  logic [3:0] be_reg;
  logic [WORD_AW-1:0] waddr_reg;
  logic [4:0] low_dw_reg;
  logic [31:0] wdata_reg;
  logic [DATA_W-1:0] tx_tdata_reg;
  logic [KEEP_W-1:0] tx_tkeep_reg;
  logic tx_tlast_reg;
  logic tx_tvalid_reg;

  // ----------------------------------------------------------------
  // Header decode of the first beat
  // ----------------------------------------------------------------
  wire rx_fire = link.rx_tvalid && rx_tready_reg;
  wire tx_fire = tx_tvalid_reg && link.tx_tready;
  wire [6:0] hdr_ft = link.rx_tdata[30:24];
  wire [9:0] hdr_len = link.rx_tdata[9:0];
  wire [HIT_W-1:0] hit = link.rx_tuser[HIT_LSB +: HIT_W];
  wire ft_mem32 = (hdr_ft == FT_MRD32) || (hdr_ft == FT_MWR32);
  wire ft_mem64 = (hdr_ft == FT_MRD64) || (hdr_ft == FT_MWR64);
  wire ft_io = (hdr_ft == FT_IORD) || (hdr_ft == FT_IOWR);
  // One BAR per space type is served, plus the expansion ROM for 32-bit memory; any other match is dropped unanswered.
  wire sel_io = ft_io && hit[HIT_IO_BIT];
  wire sel_mem32 = ft_mem32 && hit[HIT_MEM32_BIT];
  wire sel_exprom = ft_mem32 && hit[HIT_EXPROM_BIT] && !hit[HIT_MEM32_BIT];
  wire sel_mem64 = ft_mem64 && hit[HIT_MEM64_BIT];
  wire sel_any = sel_io || sel_mem32 || sel_exprom || sel_mem64;
  wire hdr_ok = sel_any && (hdr_len == LEN_ONE_DW);
  wire [1:0] sel_region = sel_io ? RGN_IO : sel_mem32 ? RGN_MEM32 : sel_mem64 ? RGN_MEM64 : RGN_EXPROM;
  // Address word sits in the low dword for 3DW headers, the high dword for 4DW.
  wire [31:0] addr_dw = is64_reg ? link.rx_tdata[63:32] : link.rx_tdata[31:0];

  // ----------------------------------------------------------------
  // Region rams
  // ----------------------------------------------------------------
  wire ram_wr = (state_reg == S_WRITE);
  wire ram_rd = (state_reg == S_READ);
  logic [31:0] rd_data [REGION_COUNT];

  for (genvar r = 0; r < REGION_COUNT; r++)
  begin : g_region
    ptmr_region_ram u_ram (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .wr_en(ram_wr && (region_reg == 2'(r))),
      .wr_addr(waddr_reg),
      .wr_be(be_reg),
      .wr_data(wdata_reg),
      .rd_en(ram_rd && (region_reg == 2'(r))),
      .rd_addr(waddr_reg),
      .rd_data(rd_data[r])
    );
  end

  wire [31:0] rd_word = rd_data[region_reg];

  // ----------------------------------------------------------------
  // Completion header
  // ----------------------------------------------------------------
  wire [6:0] cpl_ft = is_write_reg ? FT_CPL : FT_CPLD;
  wire [9:0] cpl_len = is_write_reg ? 10'h000 : LEN_ONE_DW;
  wire [11:0] cpl_bc = is_write_reg ? IO_WR_BYTE_COUNT : ptmr_byte_count(be_reg);
  wire [31:0] cpl_dw0 = {1'b0, cpl_ft, 1'b0, tc_reg, 4'h0, 2'b00, attr_reg, 2'b00, cpl_len};
  wire [31:0] cpl_dw1 = {completer_id, CPL_STATUS_SC, 1'b0, cpl_bc};
  wire [31:0] cpl_dw2 = {rid_reg, tag_reg, 1'b0, low_dw_reg, ptmr_first_byte(be_reg)};
  wire [DATA_W-1:0] cpl_beat1 = is_write_reg ? {32'h0000_0000, cpl_dw2} : {rd_word, cpl_dw2};
  wire [KEEP_W-1:0] cpl_keep1 = is_write_reg ? KEEP_LOW : KEEP_ALL;

  // ----------------------------------------------------------------
  // Receive state machine
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      S_IDLE:
        if (rx_fire)
          state_next = hdr_ok ? S_ADDR : (link.rx_tlast ? S_IDLE : S_DISCARD);
      S_ADDR:
        if (rx_fire)
          state_next = (is_write_reg && is64_reg) ? S_DATA : (is_write_reg ? S_WRITE : S_READ);
      S_DATA:
        if (rx_fire)
          state_next = S_WRITE;
      S_DISCARD:
        if (rx_fire && link.rx_tlast)
          state_next = S_IDLE;
      S_WRITE:
        state_next = is_io_reg ? S_CPL0 : S_IDLE;
      S_READ:
        state_next = S_CPL0;
      S_CPL0:
        if (tx_fire)
          state_next = S_CPL1;
      S_CPL1:
        if (tx_fire)
          state_next = S_IDLE;
    endcase
  end

  // Ready is registered, so it follows the next state; it stays low from the last
  // beat of a request until its ram access and any completion are done.
  wire accept_next = (state_next == S_IDLE) || (state_next == S_ADDR) || (state_next == S_DATA) ||
    (state_next == S_DISCARD);

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= S_IDLE;
      rx_tready_reg <= 1'b0;
      busy_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      rx_tready_reg <= accept_next;
      busy_reg <= (state_next != S_IDLE);
    end
  end

  // Request capture.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      is_write_reg <= 1'b0;
      is_io_reg <= 1'b0;
      is64_reg <= 1'b0;
      region_reg <= RGN_IO;
      tc_reg <= 3'h0;
      attr_reg <= 2'h0;
      rid_reg <= 16'h0000;
      tag_reg <= 8'h00;
      be_reg <= 4'h0;
      waddr_reg <= '0;
      low_dw_reg <= 5'h00;
      wdata_reg <= 32'h0000_0000;
    end
    else if (rx_fire && (state_reg == S_IDLE))
    begin
      is_write_reg <= link.rx_tdata[30];
      is_io_reg <= ft_io;
      is64_reg <= link.rx_tdata[29];
      region_reg <= sel_region;
      tc_reg <= link.rx_tdata[22:20];
      attr_reg <= link.rx_tdata[13:12];
      rid_reg <= link.rx_tdata[63:48];
      tag_reg <= link.rx_tdata[47:40];
      be_reg <= link.rx_tdata[35:32];
    end
    else if (rx_fire && (state_reg == S_ADDR))
    begin
      waddr_reg <= addr_dw[2 +: WORD_AW];
      low_dw_reg <= addr_dw[6:2];
      wdata_reg <= link.rx_tdata[63:32];
    end
    else if (rx_fire && (state_reg == S_DATA))
      wdata_reg <= link.rx_tdata[31:0];
  end

  // ----------------------------------------------------------------
  // Transmit side: answers only, never a request of its own
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_tvalid_reg <= 1'b0;
      tx_tdata_reg <= '0;
      tx_tkeep_reg <= '0;
      tx_tlast_reg <= 1'b0;
    end
    else if ((state_reg != S_CPL0) && (state_next == S_CPL0))
    begin
      tx_tvalid_reg <= 1'b1;
      tx_tdata_reg <= {cpl_dw1, cpl_dw0};
      tx_tkeep_reg <= KEEP_ALL;
      tx_tlast_reg <= 1'b0;
    end
    else if ((state_reg == S_CPL0) && tx_fire)
    begin
      tx_tdata_reg <= cpl_beat1;
      tx_tkeep_reg <= cpl_keep1;
      tx_tlast_reg <= 1'b1;
    end
    else if ((state_reg == S_CPL1) && tx_fire)
    begin
      tx_tvalid_reg <= 1'b0;
      tx_tlast_reg <= 1'b0;
    end
  end

  assign link.rx_tready = rx_tready_reg;
  assign link.tx_tvalid = tx_tvalid_reg;
  assign link.tx_tdata = tx_tdata_reg;
  assign link.tx_tkeep = tx_tkeep_reg;
  assign link.tx_tlast = tx_tlast_reg;
  assign busy = busy_reg;

endmodule : ptmr_device

// ===== hw/ptmr_core_end.sv
// Core-side end: forwards BAR-checked request beats on the receive stream, hands completions back.
// Assumes the user side supplies its BAR match result with each packet's first beat.
`timescale 1ns/1ps
module ptmr_core_end
  import ptmr_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // asynchronous reset, active low
  input wire logic req_valid, // request beat offered
  input wire logic [DATA_W-1:0] req_data, // request beat data
  input wire logic [KEEP_W-1:0] req_keep, // request beat byte keep
  input wire logic req_last, // last beat of packet
  input wire logic [HIT_W-1:0] req_bar_hit, // BAR match, sampled on first beat
  output logic req_ready, // request beat taken when high with req_valid
  output logic cpl_valid, // completion beat present
  output logic [DATA_W-1:0] cpl_data, // completion beat data
  output logic [KEEP_W-1:0] cpl_keep, // completion beat byte keep
  output logic cpl_last, // last completion beat
  input wire logic cpl_ready, // completion beat consumer ready
  ptmr_axis_if.core_mp link // streams to the responder
);

  // ----------------------------------------------------------------
  // Receive stage; one beat deep, trading half rate for registered ready
  // ----------------------------------------------------------------
  logic rx_valid_reg, req_ready_reg, in_pkt_reg, drop_reg;
  logic [DATA_W-1:0] rx_data_reg;
  logic [KEEP_W-1:0] rx_keep_reg;
  logic rx_last_reg;
  logic [HIT_W-1:0] hit_reg;

  wire req_take = req_valid && req_ready_reg;
  // Packets that match no BAR are consumed here and never reach the responder.
  wire drop_now = in_pkt_reg ? drop_reg : (req_bar_hit == '0);
  wire rx_load = req_take && !drop_now;
  wire rx_valid_next = rx_load || (rx_valid_reg && !link.rx_tready);

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_valid_reg <= 1'b0;
      req_ready_reg <= 1'b0;
      in_pkt_reg <= 1'b0;
      drop_reg <= 1'b0;
      rx_data_reg <= '0;
      rx_keep_reg <= '0;
      rx_last_reg <= 1'b0;
      hit_reg <= '0;
    end
    else
    begin
      rx_valid_reg <= rx_valid_next;
      req_ready_reg <= !rx_valid_next;
      if (req_take)
      begin
        in_pkt_reg <= !req_last;
        drop_reg <= drop_now;
      end
      if (rx_load)
      begin
        rx_data_reg <= req_data;
        rx_keep_reg <= req_keep;
        rx_last_reg <= req_last;
        if (!in_pkt_reg)
          hit_reg <= req_bar_hit;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit stage
  // ----------------------------------------------------------------
  logic cpl_valid_reg, tx_ready_reg, cpl_last_reg;
  logic [DATA_W-1:0] cpl_data_reg;
  logic [KEEP_W-1:0] cpl_keep_reg;

  wire tx_take = link.tx_tvalid && tx_ready_reg;
  wire cpl_valid_next = tx_take || (cpl_valid_reg && !cpl_ready);

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cpl_valid_reg <= 1'b0;
      tx_ready_reg <= 1'b0;
      cpl_data_reg <= '0;
      cpl_keep_reg <= '0;
      cpl_last_reg <= 1'b0;
    end
    else
    begin
      cpl_valid_reg <= cpl_valid_next;
      tx_ready_reg <= !cpl_valid_next;
      if (tx_take)
      begin
        cpl_data_reg <= link.tx_tdata;
        cpl_keep_reg <= link.tx_tkeep;
        cpl_last_reg <= link.tx_tlast;
      end
    end
  end

  assign link.rx_tvalid = rx_valid_reg;
  assign link.rx_tdata = rx_data_reg;
  assign link.rx_tkeep = rx_keep_reg;
  assign link.rx_tlast = rx_last_reg;
  assign link.rx_tuser = {{(USER_W-HIT_W-HIT_LSB){1'b0}}, hit_reg, 2'b00};
  assign link.tx_tready = tx_ready_reg;
  assign req_ready = req_ready_reg;
  assign cpl_valid = cpl_valid_reg;
  assign cpl_data = cpl_data_reg;
  assign cpl_keep = cpl_keep_reg;
  assign cpl_last = cpl_last_reg;

endmodule : ptmr_core_end

// ===== test/ptmr_link_properties.sv
// Concurrent checks on the stream interface that joins the core end and the responder.
// Assumes one clock domain and the 64-bit stream variant.
`timescale 1ns/1ps
module ptmr_link_properties
  import ptmr_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic reset_n, // reset, active low
  input wire logic [DATA_W-1:0] rx_tdata, // request data
  input wire logic [KEEP_W-1:0] rx_tkeep, // request keep
  input wire logic rx_tlast, // request last beat
  input wire logic rx_tvalid, // request valid
  input wire logic rx_tready, // request ready
  input wire logic [USER_W-1:0] rx_tuser, // match vector
  input wire logic [DATA_W-1:0] tx_tdata, // completion data
  input wire logic [KEEP_W-1:0] tx_tkeep, // completion keep
  input wire logic tx_tlast, // completion last beat
  input wire logic tx_tvalid, // completion valid
  input wire logic tx_tready // completion ready
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire logic tx_fire = tx_tvalid && tx_tready;
  wire logic tx_head = tx_tvalid && !tx_tlast;
  wire logic [6:0] tx_ft = tx_tdata[30:24];

  rx_hold_a: assert property (rx_tvalid && !rx_tready |=> rx_tvalid && $stable(rx_tdata))
    else $error("Request beat changed while stalled.");
  hit_field_a: assert property (rx_tvalid |-> rx_tuser[1:0] == 2'h0 && rx_tuser[21:10] == 12'h000)
    else $error("Match vector outside user bits 9:2.");
  tx_hold_a: assert property (tx_tvalid && !tx_tready |=> tx_tvalid && $stable(tx_tdata))
    else $error("Completion beat changed while stalled.");
  cpl_pair_a: assert property (tx_fire && !tx_tlast |=> tx_tvalid && tx_tlast)
    else $error("Completion second beat missing.");
  cpl_end_a: assert property (tx_fire && tx_tlast |=> !tx_tvalid && rx_tready)
    else $error("Ready not restored after completion.");
  cpl_head_a: assert property (tx_head |-> tx_tkeep == KEEP_ALL && tx_tdata[47:45] == CPL_STATUS_SC
    && (tx_ft == FT_CPLD ? tx_tdata[9:0] == LEN_ONE_DW : tx_ft == FT_CPL && tx_tdata[43:32] == IO_WR_BYTE_COUNT))
    else $error("Bad completion header.");
  cpl_stall_a: assert property (tx_tvalid |-> !rx_tready)
    else $error("Ready high while completion pending.");
  ram_wait_a: assert property (!rx_tready && !tx_tvalid |-> ##[1:3] (rx_tready || tx_tvalid))
    else $error("Ready held low too long.");
  nodata_tail_a: assert property (tx_fire && !tx_tlast && tx_ft == FT_CPL
    |=> tx_tkeep == KEEP_LOW && tx_tdata[63:32] == 32'h0000_0000)
    else $error("Completion without data carries payload.");
  cpld_c: cover property (tx_head && tx_ft == FT_CPLD);
  cpl_c: cover property (tx_head && tx_ft == FT_CPL);
  stall_c: cover property (tx_tvalid && !tx_tready);
  drop_c: cover property (rx_tvalid && rx_tready && rx_tlast ##1 rx_tready);
endmodule : ptmr_link_properties

// ===== test/pcie_target_memory_responder_test.sv
// Self-checking bench: core end and responder joined by one interface, core user side driven here.
// Assumes the 64-bit stream variant; ram words are only read after being written.
`timescale 1ns/1ps
module pcie_target_memory_responder_test;
  import ptmr_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus, ends and monitor
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic req_valid = 1'b0;
  logic [DATA_W-1:0] req_data = '0;
  logic [KEEP_W-1:0] req_keep = '0;
  logic req_last = 1'b0;
  logic [HIT_W-1:0] req_bar_hit = '0;
  logic req_ready, cpl_valid, cpl_last, busy;
  logic [DATA_W-1:0] cpl_data;
  logic [KEEP_W-1:0] cpl_keep;
  logic cpl_ready = 1'b1;
  logic stall_en = 1'b0;
  logic [15:0] cid = 16'h5AC3;
  int errors = 0;
  int n_tests = 0;
  logic [31:0] mdl [4][512];
  logic [72:0] cq [$];
  logic [72:0] eq [$];
  localparam logic [7:0] hit_tbl [4] = '{8'h01, 8'h04, 8'h02, 8'h40};
  localparam logic [6:0] wr_tbl [4] = '{FT_IOWR, FT_MWR32, FT_MWR64, FT_MWR32};
  localparam logic [6:0] rd_tbl [4] = '{FT_IORD, FT_MRD32, FT_MRD64, FT_MRD32};

  always #5 clk_sys = ~clk_sys;
  // Random back-pressure keeps completions waiting so the hold rules get exercised.
  always @(negedge clk_sys) cpl_ready <= stall_en ? 1'($urandom) : 1'b1;
  always @(posedge clk_sys) if (cpl_valid && cpl_ready) cq.push_back({cpl_last, cpl_keep, cpl_data});

  ptmr_axis_if ptmr_axis_if_i ();
  ptmr_core_end ptmr_core_end_i (.clk_sys(clk_sys), .reset_n(reset_n), .req_valid(req_valid),
    .req_data(req_data), .req_keep(req_keep), .req_last(req_last), .req_bar_hit(req_bar_hit),
    .req_ready(req_ready), .cpl_valid(cpl_valid), .cpl_data(cpl_data), .cpl_keep(cpl_keep),
    .cpl_last(cpl_last), .cpl_ready(cpl_ready), .link(ptmr_axis_if_i));
  ptmr_device ptmr_device_i (.clk_sys(clk_sys), .reset_n(reset_n), .completer_id(cid), .busy(busy),
    .link(ptmr_axis_if_i));
  ptmr_link_properties ptmr_link_properties_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .rx_tdata(ptmr_axis_if_i.rx_tdata), .rx_tkeep(ptmr_axis_if_i.rx_tkeep), .rx_tlast(ptmr_axis_if_i.rx_tlast),
    .rx_tvalid(ptmr_axis_if_i.rx_tvalid), .rx_tready(ptmr_axis_if_i.rx_tready),
    .rx_tuser(ptmr_axis_if_i.rx_tuser), .tx_tdata(ptmr_axis_if_i.tx_tdata), .tx_tkeep(ptmr_axis_if_i.tx_tkeep),
    .tx_tlast(ptmr_axis_if_i.tx_tlast), .tx_tvalid(ptmr_axis_if_i.tx_tvalid), .tx_tready(ptmr_axis_if_i.tx_tready));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic guard(input int t);
    if (t > 300)
    begin
      errors++;
      $display("[ERR] %0t wait ran out", $time);
      give_verdict();
    end
  endtask : guard

  task automatic check(input logic [72:0] got, input logic [72:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t %s: got %h, expected %h", $time, what, got, exp);
    end
  endtask : check

  function automatic int rgn(input logic [6:0] ft, input logic [7:0] hit);
    if (ft == FT_IORD || ft == FT_IOWR) return hit[0] ? 0 : -1;
    if (ft == FT_MRD64 || ft == FT_MWR64) return hit[1] ? 2 : -1;
    return hit[2] ? 1 : (hit[6] ? 3 : -1);
  endfunction : rgn

  // Sends one request through the core end and compares whatever completion comes back.
  task automatic xfer(input logic [6:0] ft, input logic [7:0] hit, input logic [31:0] addr,
    input logic [3:0] fbe, input logic [31:0] data, input logic [9:0] len, input bit chain = 1'b0);
    logic [31:0] dw [$];
    logic [2:0] tc;
    logic [1:0] attr;
    logic [15:0] rid;
    logic [7:0] tag;
    logic [72:0] b0;
    logic [72:0] b1;
    int r;
    int lo;
    int hi;
    tc = 3'($urandom);
    attr = 2'($urandom);
    rid = 16'($urandom);
    tag = 8'($urandom);
    r = rgn(ft, hit);
    dw = '{{1'b0, ft, 1'b0, tc, 6'h00, attr, 2'h0, len}, {rid, tag, 4'h0, fbe}};
    if (ft[5]) dw.push_back(32'h0000_0000);
    dw.push_back({addr[31:2], 2'h0});
    for (int i = 0; i < (ft[6] ? int'(len) : 0); i++) dw.push_back(data ^ 32'(i));
    for (int i = 0; i < dw.size(); i += 2)
    begin
      for (int t = 0; !req_ready; t++)
      begin
        guard(t);
        @(negedge clk_sys);
      end
      req_data = {(i + 1 < dw.size()) ? dw[i + 1] : ~dw[i], dw[i]};
      req_keep = (i + 1 < dw.size()) ? KEEP_ALL : KEEP_LOW;
      req_last = (i + 2 >= dw.size());
      req_bar_hit = hit;
      req_valid = 1'b1;
      @(negedge clk_sys);
    end
    req_valid = 1'b0;
    if (r >= 0 && len == LEN_ONE_DW && ft[6])
      for (int k = 0; k < 4; k++) if (fbe[k]) mdl[r][addr[10:2]][8 * k +: 8] = data[8 * k +: 8];
    if (r >= 0 && len == LEN_ONE_DW && (!ft[6] || ft == FT_IOWR))
    begin
      lo = 4;
      hi = 0;
      for (int k = 0; k < 4; k++)
      begin
        if (fbe[k])
        begin
          lo = (lo == 4) ? k : lo;
          hi = k;
        end
      end
      b0 = {1'b0, KEEP_ALL, cid, 3'h0, 1'b0, 12'(ft[6] ? 4 : (lo == 4 ? 1 : hi - lo + 1)),
        1'b0, ft[6] ? FT_CPL : FT_CPLD, 1'b0, tc, 6'h00, attr, 2'h0, ft[6] ? 10'h000 : LEN_ONE_DW};
      b1 = {1'b1, ft[6] ? KEEP_LOW : KEEP_ALL, ft[6] ? 32'h0000_0000 : mdl[r][addr[10:2]], rid, tag, 1'b0,
        addr[6:2], 2'(lo % 4)};
      eq.push_back(b0);
      eq.push_back(b1);
    end
    // A chained request leaves its completion to the next call, so the next request overlaps it.
    if (chain)
      return;
    for (int t = 0; !(req_ready && !ptmr_axis_if_i.rx_tvalid && !busy && cq.size() >= eq.size()); t++)
    begin
      guard(t);
      @(negedge clk_sys);
    end
    check(73'(cq.size()), 73'(eq.size()), "completion beats");
    while (cq.size() >= 2 && eq.size() >= 2)
    begin
      check(cq.pop_front(), eq.pop_front(), "completion header");
      check(cq.pop_front(), eq.pop_front(), "completion payload");
    end
    cq.delete();
    eq.delete();
  endtask : xfer

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(77));
    cid = 16'($urandom);
    repeat (4) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    // The same word in all four regions must stay distinct; reads 2 KB higher wrap onto it.
    for (int g = 0; g < 4; g++)
      xfer(wr_tbl[g], hit_tbl[g], 32'h0000_0010, 4'hF, {8'h5A, 8'(g), 16'hC3C3}, LEN_ONE_DW);
    for (int g = 0; g < 4; g++) xfer(rd_tbl[g], hit_tbl[g], 32'h0000_0810, 4'hF, 32'h0000_0000, LEN_ONE_DW);
    xfer(FT_MWR32, 8'h04, 32'h0000_0010, 4'h5, 32'hFFFF_FFFF, LEN_ONE_DW);
    xfer(FT_MRD32, 8'h44, 32'h0000_0010, 4'h6, 32'h0000_0000, LEN_ONE_DW);
    xfer(FT_MRD32, 8'h08, 32'h0000_0010, 4'hF, 32'h0000_0000, LEN_ONE_DW);
    xfer(FT_IORD, 8'h04, 32'h0000_0010, 4'hF, 32'h0000_0000, LEN_ONE_DW);
    xfer(FT_MWR32, 8'h04, 32'h0000_0010, 4'hF, 32'hDEAD_0000, 10'h002);
    xfer(FT_MRD64, 8'h02, 32'h0000_0010, 4'hF, 32'h0000_0000, 10'h002);
    xfer(FT_MRD32, 8'h00, 32'h0000_0010, 4'hF, 32'h0000_0000, LEN_ONE_DW);
    xfer(FT_MRD32, 8'h04, 32'h0000_0010, 4'hF, 32'h0000_0000, LEN_ONE_DW);
    stall_en = 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      int g;
      logic [31:0] a;
      g = $urandom % 4;
      a = $urandom;
      xfer(wr_tbl[g], hit_tbl[g], a, 4'hF, $urandom, LEN_ONE_DW);
      xfer(rd_tbl[g], hit_tbl[g], a, 4'($urandom), 32'h0000_0000, LEN_ONE_DW, 1'($urandom));
    end
    // A read still in flight must stall the beats of the request behind it.
    xfer(FT_MRD64, 8'h02, 32'h0000_0010, 4'h3, 32'h0000_0000, LEN_ONE_DW, 1'b1);
    xfer(FT_MWR32, 8'h04, 32'h0000_0018, 4'hF, 32'h0BAD_F00D, LEN_ONE_DW);
    give_verdict();
  end
endmodule : pcie_target_memory_responder_test
